// File: hw/res_pkg.sv
// constants of the rail enable and sequencing register block
package res_pkg;
  // ******************************************
  // register offsets
  // ******************************************
  localparam logic [7:0] ADDR_OUTPUT_ENABLE = 8'h03;
  localparam logic [7:0] ADDR_CONVERTER_MODE = 8'h04;
  localparam logic [7:0] ADDR_RAIL12_WAKE = 8'h05;
  // ******************************************
  // reset values and masks
  // ******************************************
  localparam logic [7:0] RST_OUTPUT_ENABLE = 8'h00;
  localparam logic [7:0] RST_CONVERTER_MODE = 8'h00;
  localparam logic [7:0] RST_RAIL12_WAKE = 8'h56;
  localparam logic [7:0] ENABLE_ALL_ON = 8'hfe;
  localparam logic [7:0] ENABLE_WR_MASK = 8'hfe;
  localparam logic [7:0] MODE_WR_MASK = 8'he0;
  // ******************************************
  // field positions
  // ******************************************
  localparam int BIT_MASTER = 7;
  localparam int BIT_RAIL1 = 6;
  localparam int BIT_RAIL2 = 5;
  localparam int BIT_RAIL3 = 4;
  localparam int BIT_LINREG = 3;
  localparam int BIT_EXT1 = 2;
  localparam int BIT_EXT2 = 1;
  localparam int BIT_RAIL1_PWM = 7;
  localparam int BIT_RAIL2_PWM = 6;
  localparam int BIT_RAIL3_PWM = 5;
  localparam int SLOT1_LSB = 5;
  localparam int BIT_RAIL1_KEEP = 4;
  localparam int SLOT2_LSB = 1;
  localparam int BIT_RAIL2_KEEP = 0;
  // ******************************************
  // timing
  // ******************************************
  localparam int CLK_MHZ = 50;
  localparam int WAKE_BASE_US = 150;
  localparam int WAKE_STEP_US = 512;
  localparam int WAKE_BASE_CYC = WAKE_BASE_US * CLK_MHZ;
  localparam int WAKE_STEP_CYC = WAKE_STEP_US * CLK_MHZ;
  localparam int CNT_W = 18;
  // ******************************************
  // sequencer states
  // ******************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SEQ   = 4'h2,
    ST_ON    = 4'h4,
    ST_SLEEP = 4'h8
  } res_state_t;
endpackage

// File: hw/res_rail_seq.sv
// rail enable, converter mode and wake sequencing registers
// Notes on behaviour
// - enable register, one bit per output
// - after power-up all enables set to one
// - master write zero clears register, rails off, except in the cycle the power-up sequence starts
// - master write one while off (idle, after power-up) resequences all rails
// - mode bits select forced pwm per rail
// - rail rises 150us plus slot times 512us
// - rail1 slot 7:5, rail2 slot 3:1
// - keep bit chooses rail on in sleep
module res_rail_seq #(
  parameter int BASE_CYC = res_pkg::WAKE_BASE_CYC,
  parameter int STEP_CYC = res_pkg::WAKE_STEP_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // device pins
  input  wire logic       power_up_done,
  input  wire logic       sleep_req,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // rail controls
  output logic            rail1_on,
  output logic            rail2_on,
  output logic            rail3_on,
  output logic            linreg_on,
  output logic            ext1_on,
  output logic            ext2_on,
  output logic            rail1_pwm,
  output logic            rail2_pwm,
  output logic            rail3_pwm,
  output logic            seq_busy
);
  // ******************************************
  // state
  // ******************************************
  typedef struct packed {
    res_pkg::res_state_t           fsm;
    logic [7:0]                    en;
    logic [7:0]                    mode;
    logic [7:0]                    ctl;
    logic [res_pkg::CNT_W-1:0]     count;
    logic                          pu_s1;
    logic                          pu_s2;
    logic                          sl_s1;
    logic                          sl_s2;
    logic                          pu_seen;
    logic [7:0]                    rdata;
    logic [5:0]                    rails;
    logic                          busy;
  } res_regs_t;

  res_regs_t s;
  res_regs_t next_s;

  function automatic logic [res_pkg::CNT_W-1:0] wake_cycles(input logic [2:0] slot);
    return res_pkg::CNT_W'(BASE_CYC + int'(slot) * STEP_CYC);
  endfunction

  logic [2:0] slot1;
  logic [2:0] slot2;
  logic       wr_en;
  logic       wr_mode;
  logic       wr_ctl;
  assign slot1 = s.ctl[res_pkg::SLOT1_LSB +: 3];
  assign slot2 = s.ctl[res_pkg::SLOT2_LSB +: 3];
  assign wr_en = reg_write && reg_addr == res_pkg::ADDR_OUTPUT_ENABLE;
  assign wr_mode = reg_write && reg_addr == res_pkg::ADDR_CONVERTER_MODE;
  assign wr_ctl = reg_write && reg_addr == res_pkg::ADDR_RAIL12_WAKE;

  // ******************************************
  // next state
  // ******************************************
  always_comb begin
    logic up1;
    logic up2;
    logic up0;
    up1 = 1'b0;
    up2 = 1'b0;
    up0 = 1'b0;
    next_s = s;
    next_s.pu_s1 = power_up_done;
    next_s.pu_s2 = s.pu_s1;
    next_s.sl_s1 = sleep_req;
    next_s.sl_s2 = s.sl_s1;
    if (reg_read) begin
      unique case (reg_addr)
        res_pkg::ADDR_OUTPUT_ENABLE:  next_s.rdata = s.en;
        res_pkg::ADDR_CONVERTER_MODE: next_s.rdata = s.mode;
        res_pkg::ADDR_RAIL12_WAKE:    next_s.rdata = s.ctl;
        default:                      next_s.rdata = 8'h00;
      endcase
    end
    if (wr_mode) begin
      next_s.mode = reg_wdata & res_pkg::MODE_WR_MASK;
    end
    if (wr_ctl) begin
      next_s.ctl = reg_wdata;
    end
    // the host may write any value; bit 0 is cleared, bits 7:1 are stored as given with master set (idle after power-up sets all), master zero clears all
    if (wr_en) begin
      next_s.en = reg_wdata & res_pkg::ENABLE_WR_MASK;
    end
    // counter saturates so a long stay in the sequence cannot wrap
    if (s.count != {res_pkg::CNT_W{1'b1}}) begin
      next_s.count = s.count + 1'b1;
    end
    up0 = s.count >= wake_cycles(3'h0);
    up1 = s.count >= wake_cycles(slot1);
    up2 = s.count >= wake_cycles(slot2);
    unique case (s.fsm)
      res_pkg::ST_IDLE: begin
        next_s.rails = 6'h00;
        if (s.pu_s2 && !s.pu_seen) begin
          next_s.pu_seen = 1'b1;
          next_s.en = res_pkg::ENABLE_ALL_ON;
          next_s.fsm = res_pkg::ST_SEQ;
          next_s.count = '0;
        end else if (wr_en && reg_wdata[res_pkg::BIT_MASTER] && s.pu_seen) begin
          next_s.en = res_pkg::ENABLE_ALL_ON;
          next_s.fsm = res_pkg::ST_SEQ;
          next_s.count = '0;
        end
      end
      res_pkg::ST_SEQ: begin
        // rails not timed by this block come up with the first slot
        // rails kept alive through sleep stay up on wake rather than dropping and rising again
        next_s.rails = (s.rails & s.en[6:1])
                       | {s.en[res_pkg::BIT_RAIL1] & up1, s.en[res_pkg::BIT_RAIL2] & up2,
                          s.en[res_pkg::BIT_RAIL3] & up0, s.en[res_pkg::BIT_LINREG] & up0,
                          s.en[res_pkg::BIT_EXT1] & up0, s.en[res_pkg::BIT_EXT2] & up0};
        if (up1 && up2) begin
          next_s.fsm = res_pkg::ST_ON;
        end
      end
      res_pkg::ST_ON: begin
        next_s.rails = s.en[6:1];
        if (s.sl_s2) begin
          next_s.fsm = res_pkg::ST_SLEEP;
        end
      end
      res_pkg::ST_SLEEP: begin
        next_s.rails = s.en[6:1];
        next_s.rails[5] = s.en[res_pkg::BIT_RAIL1] & s.ctl[res_pkg::BIT_RAIL1_KEEP];
        next_s.rails[4] = s.en[res_pkg::BIT_RAIL2] & s.ctl[res_pkg::BIT_RAIL2_KEEP];
        if (!s.sl_s2) begin
          next_s.fsm = res_pkg::ST_SEQ;
          next_s.count = '0;
        end
      end
      default: begin
        next_s.fsm = res_pkg::ST_IDLE;
      end
    endcase
    // master off wins over anything else in the same cycle, power-up excepted
    if (wr_en && !reg_wdata[res_pkg::BIT_MASTER] && !(s.fsm == res_pkg::ST_IDLE && s.pu_s2 && !s.pu_seen)) begin
      next_s.en = 8'h00;
      next_s.rails = 6'h00;
      next_s.fsm = res_pkg::ST_IDLE;
    end
    next_s.busy = next_s.fsm == res_pkg::ST_SEQ;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{fsm: res_pkg::ST_IDLE, en: res_pkg::RST_OUTPUT_ENABLE, mode: res_pkg::RST_CONVERTER_MODE,
             ctl: res_pkg::RST_RAIL12_WAKE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign {rail1_on, rail2_on, rail3_on, linreg_on, ext1_on, ext2_on} = s.rails;
  assign rail1_pwm = s.mode[res_pkg::BIT_RAIL1_PWM];
  assign rail2_pwm = s.mode[res_pkg::BIT_RAIL2_PWM];
  assign rail3_pwm = s.mode[res_pkg::BIT_RAIL3_PWM];
  assign seq_busy = s.busy;

  // ******************************************
  // checks
  // ******************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_master_off_clear: assert property (
    wr_en && !reg_wdata[res_pkg::BIT_MASTER] && s.pu_seen |=> s.en == 8'h00 && s.rails == 6'h00
  ) else $error("master off did not clear enables");
  a_powerup_set_all: assert property (
    s.fsm == res_pkg::ST_IDLE && s.pu_s2 && !s.pu_seen |=> s.en == res_pkg::ENABLE_ALL_ON && seq_busy
  ) else $error("power-up did not set enables");
  a_master_on_seq: assert property (
    s.fsm == res_pkg::ST_IDLE && s.pu_seen && wr_en && reg_wdata == 8'h80
    |=> s.fsm == res_pkg::ST_SEQ && s.count == '0 && s.en == res_pkg::ENABLE_ALL_ON
  ) else $error("master on did not restart sequence");
  a_mode_reserved: assert property (
    s.mode[4:0] == 5'h00 && s.en[0] == 1'b0
  ) else $error("reserved bits set");
  a_wake_delay: assert property (
    $rose(rail1_on) && $past(s.fsm) == res_pkg::ST_SEQ |-> $past(s.count) >= wake_cycles($past(slot1))
  ) else $error("rail1 rose before its slot");
  a_slot_order: assert property (
    s.fsm == res_pkg::ST_SEQ && slot2 > slot1 && s.en[res_pkg::BIT_RAIL1] && rail2_on |-> rail1_on
  ) else $error("slot order broken");
  a_sleep_off: assert property (
    s.fsm == res_pkg::ST_SLEEP && $past(s.fsm) == res_pkg::ST_SLEEP && !s.ctl[res_pkg::BIT_RAIL1_KEEP]
    |-> !rail1_on
  ) else $error("rail1 stayed on in sleep");
  a_sleep_keep: assert property (
    s.fsm == res_pkg::ST_SLEEP && $past(s.fsm) == res_pkg::ST_SLEEP && s.ctl[res_pkg::BIT_RAIL2_KEEP]
    && s.en[res_pkg::BIT_RAIL2] |-> rail2_on
  ) else $error("rail2 dropped in sleep");
  c_power_up: cover property (s.fsm == res_pkg::ST_SEQ ##1 s.fsm == res_pkg::ST_ON);
  c_sleep_entry: cover property (s.fsm == res_pkg::ST_ON ##1 s.fsm == res_pkg::ST_SLEEP);
  c_master_off: cover property (s.fsm == res_pkg::ST_ON ##1 s.fsm == res_pkg::ST_IDLE);
endmodule

// File: dv/res_host_model.sv
// host side model driving the register strobe port
module res_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  output logic            reg_read
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr  = 8'hff;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end
  // one strobe cycle, held across the sampling edge
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic wr);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_write = wr;
    reg_read  = ~wr;
    @(negedge clk);
    reg_write = 1'b0;
    reg_read  = 1'b0;
    // idle lines carry junk so stale values never look live
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // master on is only ever written as the lone master bit
  task automatic master_on();
    access(8'h03, 8'h80, 1'b1);
  endtask
endmodule

// File: dv/rail_enable_sequencing_regs_tb_top.sv
// self-checking bench for the rail enable and sequencing registers
module rail_enable_sequencing_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BASE = 10;
  localparam int STEP = 20;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       power_up_done = 1'b0;
  logic       sleep_req = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_write, reg_read, seq_busy;
  logic       rail1_on, rail2_on, rail3_on, linreg_on, ext1_on, ext2_on;
  logic       rail1_pwm, rail2_pwm, rail3_pwm;
  logic [3:0] prv = 4'h0;
  logic       rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  logic [2:0] s1, s2;
  int         failures = 0;
  int         total_checks = 0;
  int         cyc = 0;
  int         t_b, t_1, t_2, t_3;
  always #10 clk = ~clk;
  res_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
                       .reg_read(reg_read));
  res_rail_seq #(.BASE_CYC(BASE), .STEP_CYC(STEP)) dut (
    .clk(clk), .reset_n(reset_n), .power_up_done(power_up_done), .sleep_req(sleep_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rail1_on(rail1_on), .rail2_on(rail2_on), .rail3_on(rail3_on),
    .linreg_on(linreg_on), .ext1_on(ext1_on), .ext2_on(ext2_on), .rail1_pwm(rail1_pwm),
    .rail2_pwm(rail2_pwm), .rail3_pwm(rail3_pwm), .seq_busy(seq_busy));
  // ****************************************
  // checking and monitors
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(a, 8'h00, 1'b0);
  endtask
  always @(posedge clk) rd_seen <= reg_read;
  always @(negedge clk) if (rd_seen && exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
  // rise stamps, taken from pre-edge values
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prv <= {seq_busy, rail1_on, rail2_on, rail3_on};
    if (seq_busy && !prv[3]) t_b = cyc;
    if (rail1_on && !prv[2]) t_1 = cyc;
    if (rail2_on && !prv[1]) t_2 = cyc;
    if (rail3_on && !prv[0]) t_3 = cyc;
  end
  task automatic arm();
    t_b = -1;
    t_1 = -1;
    t_2 = -1;
    t_3 = -1;
  endtask
  // full is low on wake, where kept rails never fall
  task automatic seq_chk(input logic [2:0] a, input logic [2:0] b, input logic full);
    int n;
    n = 0;
    while (seq_busy !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    while (seq_busy !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    check(seq_busy, 1'b0);
    check(t_2 - t_b, BASE + b * STEP + 1);
    check({rail1_on, rail2_on, rail3_on, linreg_on, ext1_on, ext2_on}, 6'h3f);
    if (full) begin
      check(t_1 - t_b, BASE + a * STEP + 1);
      check(t_2 - t_1, (int'(b) - int'(a)) * STEP);
      check(t_3 - t_b, BASE + 1);
    end else begin
      check(t_1, -1);
      check(t_3, -1);
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(43554));
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h56);
    rd(8'h09, 8'h00);
    arm();
    power_up_done = 1'b1;
    seq_chk(3'd2, 3'd3, 1'b1);
    rd(8'h03, 8'hfe);
    repeat (3) begin
      v = 8'($urandom);
      host.access(8'h04, v, 1'b1);
      rd(8'h04, v & 8'he0);
      check({rail1_pwm, rail2_pwm, rail3_pwm}, v[7:5]);
    end
    for (int k = 0; k < 3; k++) begin
      host.access(8'h03, 8'h00, 1'b1);
      rd(8'h03, 8'h00);
      check({rail1_on, rail2_on, rail3_on, linreg_on, ext1_on, ext2_on}, 6'h00);
      s1 = (k == 0) ? 3'd7 : 3'($urandom);
      s2 = (k == 2) ? s1 : 3'($urandom);
      host.access(8'h05, {s1, 1'b1, s2, 1'b0}, 1'b1);
      rd(8'h05, {s1, 1'b1, s2, 1'b0});
      arm();
      host.master_on();
      seq_chk(s1, s2, 1'b1);
      rd(8'h03, 8'hfe);
    end
    arm();
    sleep_req = 1'b1;
    repeat (6) @(negedge clk);
    check({rail1_on, rail2_on, rail3_on}, 3'b101);
    sleep_req = 1'b0;
    seq_chk(s1, s2, 1'b0);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
